// *** hdl/slkrs_sequencer.sv ***
`timescale 1ns/1ps
module slkrs_sequencer #(
  parameter bit          SHARED_LINE = 1'b0,
  parameter int unsigned KEY_BITS    = slkrs_pkg::KEY_BITS
) (
  // Clock and reset.
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // Serial link pins.
  input  wire logic                    frame_select,
  input  wire logic                    shift_strobe_in,
  input  wire logic                    host_serial_in,
  output logic                         host_serial_out,
  output logic                         host_serial_oe,
  // Oscillator and key matrix side.
  input  wire logic                    osc_clock,
  input  wire logic                    key_pressed,
  input  wire logic [KEY_BITS-1:0]     key_state_bits,
  input  wire logic                    sleep_ack_bit,
  // Received write payload.
  output logic [slkrs_pkg::WRITE_BITS-1:0] write_data,
  output logic                         write_valid
);

  // Elaboration check: keys plus the ack bit and the closing zero must fit the read word.
  if (KEY_BITS == 0 || KEY_BITS + 2 > slkrs_pkg::READ_BITS) begin : g_bad_key_bits
    $error("slkrs_sequencer: KEY_BITS out of range");
  end

  // Two-flop synchronisers for the pins and the oscillator.
  // Reset loads the idle levels (frame and strobe low, data pulled high) so no false edge follows reset.
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [2:0] prev;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_a <= 4'h2;
      sync_b <= 4'h2;
      prev   <= 3'h0;
    end else begin
      sync_a <= {frame_select, shift_strobe_in, host_serial_in, osc_clock};
      sync_b <= sync_a;
      prev   <= {sync_b[3], sync_b[2], sync_b[0]};
    end
  end

  wire fs       = sync_b[3];
  wire strobe   = sync_b[2];
  wire din      = sync_b[1];
  wire osc      = sync_b[0];
  wire fs_rise  = fs && !prev[2];
  wire fs_fall  = !fs && prev[2];
  wire sck_rise = strobe && !prev[1];
  wire sck_fall = !strobe && prev[1];
  wire osc_tick = osc && !prev[0];

  slkrs_pkg::slkrs_state_t state;
  slkrs_pkg::slkrs_state_t next_state;
  logic [7:0]  addr_shift;
  logic [2:0]  addr_count;
  logic [slkrs_pkg::WRITE_BITS-1:0] wshift;
  logic [slkrs_pkg::READ_BITS-1:0] rshift;
  logic        session_open;
  logic        request;
  logic [KEY_BITS-1:0] last_keys;
  logic        scan_start;
  logic        scan_done;
  logic        scanning;
  logic        pressed_q;

  wire [7:0] addr_byte   = {din, addr_shift[7:1]};
  wire       addr_full   = sck_rise && (addr_count == 3'h7);
  wire       is_write    = addr_byte == slkrs_pkg::ADDR_WRITE;
  wire       is_read     = addr_byte == slkrs_pkg::ADDR_READ;
  wire       is_start    = SHARED_LINE && addr_byte == slkrs_pkg::CMD_START;
  wire       is_stop     = SHARED_LINE && addr_byte == slkrs_pkg::CMD_STOP;
  wire       may_transfer = !SHARED_LINE || session_open;
  wire       scans_agree  = key_state_bits == last_keys;
  wire       read_end     = state == slkrs_pkg::SLKRS_READ && fs_fall;

  // Frame sequencing: address byte selects direction.
  always_comb begin
    next_state = state;
    unique case (state)
      slkrs_pkg::SLKRS_IDLE: begin
        if (fs_rise) begin
          next_state = slkrs_pkg::SLKRS_ADDR;
        end
      end
      slkrs_pkg::SLKRS_ADDR: begin
        if (!fs) begin
          next_state = slkrs_pkg::SLKRS_IDLE;
        end else if (addr_full) begin
          if (is_write && may_transfer) begin
            next_state = slkrs_pkg::SLKRS_WRITE;
          end else if (is_read && may_transfer) begin
            next_state = slkrs_pkg::SLKRS_READ;
          end else begin
            next_state = slkrs_pkg::SLKRS_SKIP;
          end
        end
      end
      slkrs_pkg::SLKRS_WRITE,
      slkrs_pkg::SLKRS_READ,
      slkrs_pkg::SLKRS_SKIP: begin
        if (!fs) begin
          next_state = slkrs_pkg::SLKRS_IDLE;
        end
      end
      default: begin
        next_state = slkrs_pkg::SLKRS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= slkrs_pkg::SLKRS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Address shifter, least significant bit first.
  always_ff @(posedge clk_sys) begin
    if (reset || fs_rise) begin
      addr_shift <= 8'h00;
      addr_count <= 3'h0;
    end else if (state == slkrs_pkg::SLKRS_ADDR && sck_rise) begin
      addr_shift <= addr_byte;
      addr_count <= addr_count + 3'h1;
    end
  end

  // Write payload shifter; delivered when frame select falls.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wshift      <= '0;
      write_data  <= '0;
      write_valid <= 1'b0;
    end else begin
      write_valid <= 1'b0;
      if (state == slkrs_pkg::SLKRS_WRITE && sck_rise) begin
        wshift    <= {din, wshift[slkrs_pkg::WRITE_BITS-1:1]};
      end else if (state == slkrs_pkg::SLKRS_WRITE && fs_fall) begin
        write_data  <= wshift;
        write_valid <= 1'b1;
      end
    end
  end

  // Session flag: start opens, stop or a finished read closes.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      session_open <= 1'b0;
    end else if (state == slkrs_pkg::SLKRS_ADDR && addr_full && is_start) begin
      session_open <= 1'b1;
    end else if (read_end || (state == slkrs_pkg::SLKRS_ADDR && addr_full && is_stop)) begin
      session_open <= 1'b0;
    end
  end

  // Key scan launch and settle; request rises when the result is settled.
  assign scan_start = key_pressed && !pressed_q && !scanning;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pressed_q <= 1'b0;
      scanning  <= 1'b0;
      last_keys <= '0;
      request   <= 1'b0;
    end else begin
      pressed_q <= key_pressed;
      if (scan_start) begin
        scanning <= 1'b1;
      end else if (scan_done) begin
        scanning  <= 1'b0;
        last_keys <= key_state_bits;
      end
      if (scan_done) begin
        request <= 1'b1;
      end else if (read_end) begin
        request <= 1'b0;
      end
    end
  end

  slkrs_scan_timer u_timer (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .osc_tick    (osc_tick),
    .scan_start  (scan_start),
    .scans_agree (scans_agree),
    .scan_done   (scan_done)
  );

  // Read shifter: keys then sleep ack, shifted out on falling strobe; zero-filled above.
  localparam int unsigned READ_W = slkrs_pkg::READ_BITS;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rshift <= '0;
    end else if (state == slkrs_pkg::SLKRS_ADDR && addr_full && is_read) begin
      rshift <= READ_W'({sleep_ack_bit, last_keys});
    end else if (state == slkrs_pkg::SLKRS_READ && sck_fall) begin
      rshift <= {1'b0, rshift[slkrs_pkg::READ_BITS-1:1]};
    end
  end

  // Open-drain output: drive low for request or a zero data bit.
  wire watch_ok  = !SHARED_LINE || !session_open;
  // A finishing read must not leave a one-cycle false request on the line.
  wire drive_req = !fs && request && !read_end && watch_ok;
  wire drive_dat = state == slkrs_pkg::SLKRS_READ && !rshift[0];
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      host_serial_out <= 1'b0;
      host_serial_oe  <= 1'b0;
    end else begin
      host_serial_out <= 1'b0;
      host_serial_oe  <= drive_req || drive_dat;
    end
  end

endmodule : slkrs_sequencer

// *** hdl/slkrs_pkg.sv ***
package slkrs_pkg;

  // Bus addresses carried in the first byte after frame select rises.
  localparam logic [7:0] ADDR_WRITE   = 8'h42;
  localparam logic [7:0] ADDR_READ    = 8'h43;
  localparam logic [7:0] CMD_START    = 8'hA5;
  localparam logic [7:0] CMD_STOP     = 8'h5A;

  // Key scan times in oscillator periods.
  localparam int unsigned SCAN_AGREE_PERIODS    = 615;
  localparam int unsigned SCAN_DISAGREE_PERIODS = 1230;

  // Sizes of the key result, of a read word and of a write payload.
  localparam int unsigned KEY_BITS      = 30;
  localparam int unsigned READ_BITS     = 32;
  localparam int unsigned WRITE_BITS    = 64;

  typedef enum logic [2:0] {
    SLKRS_IDLE  = 3'b000,
    SLKRS_ADDR  = 3'b001,
    SLKRS_WRITE = 3'b010,
    SLKRS_READ  = 3'b011,
    SLKRS_SKIP  = 3'b100
  } slkrs_state_t;

endpackage : slkrs_pkg

// *** hdl/slkrs_scan_timer.sv ***
`timescale 1ns/1ps
// Counts oscillator edges for one key scan; a disagreeing pair doubles the time.
module slkrs_scan_timer #(
  parameter int unsigned AGREE_PERIODS    = slkrs_pkg::SCAN_AGREE_PERIODS,
  parameter int unsigned DISAGREE_PERIODS = slkrs_pkg::SCAN_DISAGREE_PERIODS
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Oscillator tick and scan control.
  input  wire logic        osc_tick,
  input  wire logic        scan_start,
  input  wire logic        scans_agree,
  output logic             scan_done
);

  localparam int unsigned CW = $clog2(DISAGREE_PERIODS + 1);

  logic [CW-1:0] count;
  logic          busy;
  wire  [CW-1:0] limit = scans_agree ? CW'(AGREE_PERIODS) : CW'(DISAGREE_PERIODS);
  wire           at_end = busy && osc_tick && (count == limit - CW'(1));

  // Elaboration check: the longer scan must not be shorter than the agreeing one.
  if (AGREE_PERIODS == 0 || DISAGREE_PERIODS < AGREE_PERIODS) begin : g_bad_periods
    $error("slkrs_scan_timer: bad scan period parameters");
  end

  // Restart on a new scan; agreement is looked at only when the count ends.
  always_ff @(posedge clk_sys) begin
    if (reset || scan_start) begin
      count <= '0;
      busy  <= scan_start && !reset;
    end else if (at_end) begin
      busy  <= 1'b0;
    end else if (busy && osc_tick) begin
      count <= count + CW'(1);
    end
  end

  // Registered end pulse, one cycle after the last counted tick.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scan_done <= 1'b0;
    end else begin
      scan_done <= at_end;
    end
  end

endmodule : slkrs_scan_timer

// *** bench/slkrs_monitor.sv ***
`timescale 1ns/1ps
module slkrs_monitor (
  // Clock, reset and inputs.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic frame_select,
  input wire logic osc_clock,
  input wire logic key_pressed,
  // Design outputs.
  input wire logic host_serial_out,
  input wire logic host_serial_oe,
  input wire logic write_valid
);
  logic [3:0]  low_cnt;
  logic [11:0] osc_cnt;
  logic        osc_q;
  logic        key_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Cycles since the frame closed, and oscillator rises since the key went down; both saturate.
  always_ff @(posedge clk_sys) begin
    osc_q <= osc_clock;
    key_q <= key_pressed;
    low_cnt <= (reset || frame_select) ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
    osc_cnt <= (reset || (key_pressed && !key_q)) ? 12'h000 : osc_cnt + {11'h0, osc_clock && !osc_q && osc_cnt != 12'hFFF};
  end
  a_drive_only_low: assert property (host_serial_out == 1'b0) else $error("output level not low");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !host_serial_oe && !write_valid) else $error("active after reset");
  a_valid_one_cycle: assert property (write_valid |=> !write_valid) else $error("valid longer than one cycle");
  a_valid_after_frame: assert property (write_valid |-> !frame_select && low_cnt inside {[1:8]})
    else $error("valid outside frame end");
  a_scan_time_bound: assert property ($rose(host_serial_oe) && low_cnt == 4'hF |-> osc_cnt inside {[614:1233]})
    else $error("scan time out of range");
  a_request_holds: assert property ($fell(host_serial_oe) && !frame_select |-> low_cnt < 4'h8)
    else $error("request dropped while idle");
  c_write: cover property (write_valid);
  c_request: cover property ($rose(host_serial_oe) && low_cnt == 4'hF);
  c_cleared: cover property ($fell(host_serial_oe) && !frame_select);
endmodule : slkrs_monitor

// *** bench/slkrs_host_model.sv ***
`timescale 1ns/1ps
module slkrs_host_model (
  // Clock and line level seen by the controller.
  input  wire logic clk_sys,
  input  wire logic line_in,
  // Link pins driven by the controller.
  output logic      frame_select,
  output logic      shift_strobe_in,
  output logic      data_drive
);
  // Strobe stands low and the data line is released to the pull-up between frames.
  initial begin
    frame_select = 1'b0;
    shift_strobe_in = 1'b0;
    data_drive = 1'b1;
  end
  // Framed address then data, LSB first; the line is released during a read.
  task automatic frame(input logic [7:0] addr, input int n, input logic [63:0] d, input bit rd,
                       output logic [63:0] q);
    logic [71:0] bits;
    bits = {d, addr};
    q = '0;
    @(posedge clk_sys) frame_select <= 1'b1;
    for (int i = 0; i < 8 + n; i++) begin
      @(posedge clk_sys) shift_strobe_in <= 1'b0;
      data_drive <= (rd && i >= 8) ? 1'b1 : bits[i];
      repeat (3) @(posedge clk_sys);
      // Sample a cycle before the rise: the device's output flop may change on the rise edge itself.
      if (i >= 8) q[i-8] = line_in;
      @(posedge clk_sys) shift_strobe_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys) shift_strobe_in <= 1'b0;
    data_drive <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(posedge clk_sys) frame_select <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : frame
endmodule : slkrs_host_model

// *** bench/tb_serial_link_key_request_sequencer.sv ***
`timescale 1ns/1ps
module tb_serial_link_key_request_sequencer;
  logic clk_sys, reset, osc_clock, key_pressed, sleep_ack_bit, frame_select, shift_strobe_in, data_drive;
  logic host_serial_out, host_serial_oe, write_valid;
  logic [29:0] key_state_bits;
  logic [63:0] write_data, q, sep_data;
  logic sep_oe;
  wire  host_serial_in = data_drive & ~host_serial_oe;
  int   num_checks = 0, miscompares = 0, nvalid = 0;
  slkrs_sequencer #(.SHARED_LINE(1'b1)) uut (.clk_sys(clk_sys), .reset(reset), .frame_select(frame_select),
    .shift_strobe_in(shift_strobe_in), .host_serial_in(host_serial_in), .host_serial_out(host_serial_out),
    .host_serial_oe(host_serial_oe), .osc_clock(osc_clock), .key_pressed(key_pressed),
    .key_state_bits(key_state_bits), .sleep_ack_bit(sleep_ack_bit), .write_data(write_data), .write_valid(write_valid));
  slkrs_host_model host (.clk_sys(clk_sys), .line_in(host_serial_in), .frame_select(frame_select),
    .shift_strobe_in(shift_strobe_in), .data_drive(data_drive));
  // Separate-line twin on the same pins: no start or stop needed, its output line is its own.
  slkrs_sequencer #(.SHARED_LINE(1'b0)) uut_sep (.clk_sys(clk_sys), .reset(reset), .frame_select(frame_select),
    .shift_strobe_in(shift_strobe_in), .host_serial_in(data_drive), .host_serial_out(), .host_serial_oe(sep_oe),
    .osc_clock(osc_clock), .key_pressed(key_pressed), .key_state_bits(key_state_bits),
    .sleep_ack_bit(sleep_ack_bit), .write_data(sep_data), .write_valid());
  // The oscillator runs free at 200 ns, four system clock periods, changing on falling clock edges.
  always #25 clk_sys = ~clk_sys;
  always #100 osc_clock = ~osc_clock;
  always @(posedge clk_sys) if (write_valid === 1'b1) nvalid <= nvalid + 1;
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // A write with no open session must leave the payload untouched.
  task automatic t_write_refused;
    int n0;
    n0 = nvalid;
    host.frame(slkrs_pkg::ADDR_WRITE, 64, 64'h0F1E_2D3C_4B5A_6978, 0, q);
    chk("refused write count", n0, nvalid);
    chk("separate write data", 64'h0F1E_2D3C_4B5A_6978, sep_data);
  endtask : t_write_refused
  // Start, addressed write, stop; payload lands LSB first.
  task automatic t_write_session(input logic [63:0] d);
    int n0;
    n0 = nvalid;
    host.frame(slkrs_pkg::CMD_START, 0, 64'h0, 0, q);
    host.frame(slkrs_pkg::ADDR_WRITE, 64, d, 0, q);
    host.frame(slkrs_pkg::CMD_STOP, 0, 64'h0, 0, q);
    chk("write count", n0 + 1, nvalid);
    chk("write data", d, write_data);
    chk("separate write data", d, sep_data);
  endtask : t_write_session
  // Key press, timed request, readout that closes the session by itself.
  task automatic t_scan(input logic [29:0] k, input logic sa, input int lo, input int hi);
    int cnt;
    key_state_bits <= k;
    sleep_ack_bit <= sa;
    @(posedge clk_sys) key_pressed <= 1'b1;
    for (cnt = 0; cnt < 6000 && host_serial_oe !== 1'b1; cnt++) @(posedge clk_sys);
    if (cnt == 6000) begin
      miscompares++;
      tally_and_finish();
    end
    chk("scan time in window", 64'h1, {63'h0, cnt >= lo && cnt <= hi});
    chk("separate request", 64'h1, {63'h0, sep_oe});
    key_pressed <= 1'b0;
    host.frame(slkrs_pkg::CMD_START, 0, 64'h0, 0, q);
    host.frame(slkrs_pkg::ADDR_READ, 32, 64'h0, 1, q);
    chk("key data and ack", {32'h0, 1'b0, sa, k}, {32'h0, q[31:0]});
    chk("request cleared", 64'h0, {63'h0, host_serial_oe});
    chk("separate request cleared", 64'h0, {63'h0, sep_oe});
    t_write_refused();
  endtask : t_scan
  initial begin
    clk_sys = 1'b0;
    osc_clock = 1'b0;
    reset = 1'b1;
    key_pressed = 1'b0;
    key_state_bits = '0;
    sleep_ack_bit = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("oe after reset", 64'h0, {63'h0, host_serial_oe});
    t_write_refused();
    t_write_session(64'hA55A_C33C_0FF0_1234);
    t_scan(30'h2AAA_5555, 1'b1, 4800, 6000);
    t_scan(30'h2AAA_5555, 1'b0, 2400, 3700);
    t_scan(30'h1234_5678, 1'b1, 4800, 6000);
    tally_and_finish();
  end
endmodule : tb_serial_link_key_request_sequencer
bind slkrs_sequencer slkrs_monitor mon (.clk_sys(clk_sys), .reset(reset), .frame_select(frame_select),
  .osc_clock(osc_clock), .key_pressed(key_pressed), .host_serial_out(host_serial_out),
  .host_serial_oe(host_serial_oe), .write_valid(write_valid));
